// ===== core/akrc_pkg.sv
// akrc_pkg: task-file offsets, opcodes, states and carriers for the command executor
// assumes: used by core/akrc_exec.sv and core/akrc_fifo.sv
package akrc_pkg;

  // ------------------------------------------------------------
  // task-file offsets
  // ------------------------------------------------------------
  localparam logic [2:0] AKRC_OFF_DATA    = 3'h0;
  localparam logic [2:0] AKRC_OFF_FEATURE = 3'h1;
  localparam logic [2:0] AKRC_OFF_COUNT   = 3'h2;
  localparam logic [2:0] AKRC_OFF_SECIDX  = 3'h3;
  localparam logic [2:0] AKRC_OFF_CYLLO   = 3'h4;
  localparam logic [2:0] AKRC_OFF_CYLHI   = 3'h5;
  localparam logic [2:0] AKRC_OFF_DRVHD   = 3'h6;
  localparam logic [2:0] AKRC_OFF_OPCODE  = 3'h7;

  // ------------------------------------------------------------
  // opcodes and subcommands
  // ------------------------------------------------------------
  localparam logic [7:0]  AKRC_OP_KEYMGMT   = 8'hb9;
  localparam logic [7:0]  AKRC_FEAT_KEYREAD = 8'h80;
  localparam logic [7:0]  AKRC_FEAT_KEYCHG  = 8'h81;
  localparam logic [15:0] AKRC_GUARD_WORD   = 16'hb26e;
  localparam logic [7:0]  AKRC_OP_NOP       = 8'h00;
  localparam logic [7:0]  AKRC_OP_RDBUF     = 8'he4;
  localparam logic [7:0]  AKRC_OP_RDDMA     = 8'hc8;
  localparam logic [7:0]  AKRC_OP_RDLONG0   = 8'h22;
  localparam logic [7:0]  AKRC_OP_RDLONG1   = 8'h23;

  // ------------------------------------------------------------
  // status and error bits, field positions, counts
  // ------------------------------------------------------------
  localparam int         AKRC_ST_BSY     = 7;
  localparam int         AKRC_ST_DRDY    = 6;
  localparam int         AKRC_ST_DRQ     = 3;
  localparam int         AKRC_ST_ERR     = 0;
  localparam logic [7:0] AKRC_ERR_ABRT   = 8'h04;
  localparam logic [7:0] AKRC_ERR_UNC    = 8'h40;
  localparam int         AKRC_DH_LBA     = 6;
  localparam logic [7:0] AKRC_WORDS_SECT = 8'hff;   // 256 words minus one
  localparam logic [1:0] AKRC_CHK_BYTES  = 2'h3;    // 4 check bytes minus one
  localparam logic [8:0] AKRC_MAX_SECTS  = 9'h100;
  localparam int         AKRC_FIFO_DEPTH = 4;
  localparam logic [7:0] AKRC_RST_STATUS = 8'h40;

  // ------------------------------------------------------------
  // executor states and carriers
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    AKRC_IDLE, AKRC_FETCH, AKRC_PIO_XFER, AKRC_CHK_XFER, AKRC_DMA_XFER, AKRC_DONE
  } akrc_state_t;

  typedef struct packed {
    logic [15:0] data;
    logic        byte_mode;
  } akrc_word_t;

  typedef struct packed {
    logic [7:0] drvhd;
    logic [7:0] cylhi;
    logic [7:0] cyllo;
    logic [7:0] secidx;
  } akrc_addr_t;

endpackage : akrc_pkg

// ===== core/akrc_fifo.sv
// akrc_fifo: small valid/ready FIFO on the read data path
// assumes: single clock, asynchronous active-low reset
module akrc_fifo
  import akrc_pkg::*;
#(
  parameter int WIDTH = 17,
  parameter int DEPTH = 4
) (
  input  wire logic             CLK,
  input  wire logic             NRST,
  input  wire logic             CLR,
  input  wire logic [WIDTH-1:0] IN_DATA,
  input  wire logic             IN_VALID,
  output logic                  IN_READY,
  output logic [WIDTH-1:0]      OUT_DATA,
  output logic                  OUT_VALID,
  input  wire logic             OUT_READY
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  wire              push = IN_VALID && IN_READY;
  wire              pop  = OUT_VALID && OUT_READY;

  assign IN_READY  = (cnt_q != (AW+1)'(DEPTH));
  assign OUT_VALID = (cnt_q != '0);
  assign OUT_DATA  = mem_q[rd_q];

  // ------------------------------------------------------------
  // storage and pointers
  // ------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (push) begin
      mem_q[wr_q] <= IN_DATA;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (CLR) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : akrc_fifo

// ===== core/akrc_exec.sv
// akrc_exec: task file and execution of key-management, nop, buffer, dma and long reads
// assumes: host strobes and media port synchronous to CLK; media supplies words on request
module akrc_exec
  import akrc_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic [2:0]  ADDR,
  input  wire logic        WR_STB,
  input  wire logic        RD_STB,
  input  wire logic [7:0]  WDATA,
  output logic [15:0]      RDATA,
  output logic [7:0]       STATUS,
  output logic [7:0]       ERROR,
  output logic             INTRQ,
  input  wire logic        EIGHT_BIT_MODE,
  output logic             DMARQ,
  input  wire logic        DMACK,
  input  wire logic        DMA_RD_STB,
  output logic             MEDIA_REQ,
  output logic [1:0]       MEDIA_SRC,
  output logic [27:0]      MEDIA_ADDR,
  output logic             MEDIA_CHK,
  output logic             MEDIA_CHG,
  input  wire logic        MEDIA_VALID,
  input  wire logic [15:0] MEDIA_DATA,
  input  wire logic        MEDIA_ERR,
  output logic             MEDIA_READY
);
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  akrc_state_t state_q, state_d;
  logic [7:0]  feat_q, count_q, secidx_q, cyllo_q, cylhi_q, drvhd_q;
  logic [7:0]  status_q, error_q;
  logic        intrq_q;
  logic [8:0]  left_q;
  logic [7:0]  words_q;
  logic [1:0]  chk_q;
  logic        rdlong_q, dma_q, key_q, buf_q;
  logic [15:0] rdata_q;
  logic [8:0]  pushed_q;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire         wr_opcode  = WR_STB && (ADDR == AKRC_OFF_OPCODE) && !status_q[AKRC_ST_BSY];
  wire         wr_tf      = WR_STB && !status_q[AKRC_ST_BSY] && !status_q[AKRC_ST_DRQ];
  wire         is_key     = (WDATA == AKRC_OP_KEYMGMT);
  wire         key_read   = is_key && (feat_q == AKRC_FEAT_KEYREAD);
  wire         guard_ok   = ({cylhi_q, cyllo_q} == AKRC_GUARD_WORD);
  wire         key_chg    = is_key && (feat_q == AKRC_FEAT_KEYCHG) && guard_ok;
  wire         is_rdlong  = (WDATA == AKRC_OP_RDLONG0) || (WDATA == AKRC_OP_RDLONG1);
  wire         is_dma     = (WDATA == AKRC_OP_RDDMA) && !EIGHT_BIT_MODE;
  wire         is_rdbuf   = (WDATA == AKRC_OP_RDBUF);
  wire         do_abort   = !(key_read || key_chg || is_rdlong || is_dma || is_rdbuf);
  wire [8:0]   req_count  = (count_q == 8'h00) ? AKRC_MAX_SECTS : {1'b0, count_q};
  wire [27:0]  lba        = {drvhd_q[3:0], cylhi_q, cyllo_q, secidx_q};
  wire [15:0]  key_off    = {cyllo_q, secidx_q};
  wire [27:0]  next_lba   = lba + 28'h1;
  wire [15:0]  next_off   = key_off + 16'h1;

  // fifo between media and host
  akrc_word_t  fin, fout;
  logic        fin_ready, fout_valid, fout_ready;
  wire         media_take = MEDIA_VALID && fin_ready && MEDIA_READY;
  wire         host_pio   = RD_STB && (ADDR == AKRC_OFF_DATA) && status_q[AKRC_ST_DRQ];
  wire         host_dma   = DMACK && DMA_RD_STB && dma_q;
  wire         pop        = fout_valid && (host_pio || host_dma);
  wire         sect_end   = pop && (words_q == 8'h00) && !fout.byte_mode;
  wire         chk_end    = pop && fout.byte_mode && (chk_q == 2'h0);
  wire         xfer       = (state_q == AKRC_PIO_XFER) || (state_q == AKRC_DMA_XFER)
                            || (state_q == AKRC_CHK_XFER);
  wire         fifo_clr   = (state_q == AKRC_IDLE);

  // words past the first 256 of a long read are check bytes, tagged byte_mode as pushed
  assign fin           = '{data: MEDIA_DATA, byte_mode: rdlong_q && pushed_q[8]};
  assign fout_ready    = host_pio || host_dma;

  akrc_fifo #(
    .WIDTH ($bits(akrc_word_t)),
    .DEPTH (AKRC_FIFO_DEPTH)
  ) u_fifo (
    .CLK       (CLK),
    .NRST      (NRST),
    .CLR       (fifo_clr),
    .IN_DATA   (fin),
    .IN_VALID  (MEDIA_VALID && MEDIA_READY),
    .IN_READY  (fin_ready),
    .OUT_DATA  (fout),
    .OUT_VALID (fout_valid),
    .OUT_READY (fout_ready)
  );

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign MEDIA_READY = xfer && fin_ready && !MEDIA_ERR;
  assign MEDIA_REQ   = (state_q == AKRC_FETCH);
  assign MEDIA_SRC   = key_q ? 2'h1 : (buf_q ? 2'h2 : 2'h0);
  assign MEDIA_ADDR  = key_q ? {12'h000, key_off} : lba;
  assign MEDIA_CHK   = !rdlong_q;
  assign MEDIA_CHG   = wr_opcode && key_chg;
  assign DMARQ       = dma_q && (state_q == AKRC_DMA_XFER) && fout_valid;
  assign RDATA       = rdata_q;
  assign STATUS      = status_q;
  assign ERROR       = error_q;
  assign INTRQ       = intrq_q;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      AKRC_IDLE: begin
        if (wr_opcode && !do_abort && !key_chg) begin
          state_d = AKRC_FETCH;
        end
      end
      AKRC_FETCH: begin
        state_d = dma_q ? AKRC_DMA_XFER : AKRC_PIO_XFER;
      end
      AKRC_PIO_XFER, AKRC_DMA_XFER: begin
        if (MEDIA_ERR) begin
          state_d = AKRC_DONE;
        end else if (sect_end && rdlong_q) begin
          state_d = AKRC_CHK_XFER;
        end else if (sect_end) begin
          state_d = (left_q == 9'h001) ? AKRC_DONE : (dma_q ? state_q : AKRC_FETCH);
        end
      end
      AKRC_CHK_XFER: begin
        if (chk_end || MEDIA_ERR) begin
          state_d = AKRC_DONE;
        end
      end
      AKRC_DONE: begin
        state_d = AKRC_IDLE;
      end
      default: begin
        state_d = AKRC_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------
  // sequencing
  // ------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_q  <= AKRC_IDLE;
      left_q   <= '0;
      words_q  <= '0;
      chk_q    <= '0;
      rdlong_q <= 1'b0;
      dma_q    <= 1'b0;
      key_q    <= 1'b0;
      buf_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      if (wr_opcode) begin
        rdlong_q <= is_rdlong;
        dma_q    <= is_dma;
        key_q    <= key_read;
        buf_q    <= is_rdbuf;
        left_q   <= (is_rdlong || is_rdbuf) ? 9'h001 : req_count;
        words_q  <= AKRC_WORDS_SECT;
        chk_q    <= AKRC_CHK_BYTES;
      end else if (sect_end) begin
        words_q <= AKRC_WORDS_SECT;
        left_q  <= left_q - 9'h001;
      end else if (pop && fout.byte_mode) begin
        chk_q <= chk_q - 2'h1;
      end else if (pop) begin
        words_q <= words_q - 8'h01;
      end
    end
  end

  // ------------------------------------------------------------
  // host read data
  // ------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rdata_q <= '0;
    end else if (pop) begin
      rdata_q <= fout.byte_mode ? {8'h00, fout.data[7:0]} : fout.data;
    end
  end

  // words taken from the media since the last request
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pushed_q <= '0;
    end else if (MEDIA_REQ) begin
      pushed_q <= '0;
    end else if (media_take) begin
      pushed_q <= pushed_q + 9'h001;
    end
  end

  // ------------------------------------------------------------
  // task file
  // ------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      feat_q   <= '0;
      count_q  <= '0;
      secidx_q <= '0;
      cyllo_q  <= '0;
      cylhi_q  <= '0;
      drvhd_q  <= '0;
    end else if (wr_tf && (ADDR != AKRC_OFF_OPCODE)) begin
      case (ADDR)
        AKRC_OFF_FEATURE: feat_q   <= WDATA;
        AKRC_OFF_COUNT:   count_q  <= WDATA;
        AKRC_OFF_SECIDX:  secidx_q <= WDATA;
        AKRC_OFF_CYLLO:   cyllo_q  <= WDATA;
        AKRC_OFF_CYLHI:   cylhi_q  <= WDATA;
        AKRC_OFF_DRVHD:   drvhd_q  <= WDATA;
        default:          feat_q   <= feat_q;
      endcase
    end else if (sect_end && (left_q != 9'h001) && !rdlong_q && !buf_q) begin
      if (key_q) begin
        {cyllo_q, secidx_q} <= next_off;
      end else if (drvhd_q[AKRC_DH_LBA]) begin
        {drvhd_q[3:0], cylhi_q, cyllo_q, secidx_q} <= next_lba;
      end
    end
  end

  // ------------------------------------------------------------
  // status, error and interrupt
  // ------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      status_q <= AKRC_RST_STATUS;
      error_q  <= '0;
      intrq_q  <= 1'b0;
    end else begin
      if (wr_opcode) begin
        intrq_q <= 1'b0;
        if (do_abort) begin
          status_q <= AKRC_RST_STATUS | 8'h01;
          error_q  <= AKRC_ERR_ABRT;
          intrq_q  <= 1'b1;
        end else if (key_chg) begin
          status_q <= AKRC_RST_STATUS;
          error_q  <= '0;
          intrq_q  <= 1'b1;
        end else begin
          status_q <= AKRC_RST_STATUS | 8'h80;
          error_q  <= '0;
        end
      end else if (RD_STB && (ADDR == AKRC_OFF_OPCODE)) begin
        intrq_q <= 1'b0;
      end
      if (!wr_opcode) begin
        if (state_q == AKRC_FETCH) begin
          status_q[AKRC_ST_BSY] <= 1'b1;
          status_q[AKRC_ST_DRQ] <= 1'b0;
        end else if (xfer && MEDIA_ERR) begin
          status_q <= AKRC_RST_STATUS | 8'h01;
          error_q  <= AKRC_ERR_UNC;
          intrq_q  <= 1'b1;
        end else if (xfer && fout_valid && status_q[AKRC_ST_BSY]) begin
          status_q[AKRC_ST_BSY] <= 1'b0;
          status_q[AKRC_ST_DRQ] <= 1'b1;
          if (!dma_q) begin
            intrq_q <= 1'b1;
          end
        end else if (state_q == AKRC_DONE) begin
          status_q[AKRC_ST_BSY] <= 1'b0;
          status_q[AKRC_ST_DRQ] <= 1'b0;
          if (dma_q && !status_q[AKRC_ST_ERR]) begin
            intrq_q <= 1'b1;
          end
        end
      end
    end
  end
endmodule : akrc_exec

// ===== verif/akrc_exec_assertions.sv
// akrc_exec_assertions: port-level checks of the command executor
// assumes: bound into akrc_exec; task file rewritten before each opcode
module akrc_exec_assertions
  import akrc_pkg::*;
(
  input wire logic        CLK,
  input wire logic        NRST,
  input wire logic [2:0]  ADDR,
  input wire logic        WR_STB,
  input wire logic [7:0]  WDATA,
  input wire logic [7:0]  STATUS,
  input wire logic [7:0]  ERROR,
  input wire logic        INTRQ,
  input wire logic        EIGHT_BIT_MODE,
  input wire logic        DMARQ,
  input wire logic        MEDIA_REQ,
  input wire logic [1:0]  MEDIA_SRC,
  input wire logic [27:0] MEDIA_ADDR,
  input wire logic        MEDIA_CHK,
  input wire logic        MEDIA_CHG
);
  // ----------------------------------------
  // task-file shadow
  // ----------------------------------------
  logic [7:0] feat_q, sec_q, lo_q, hi_q, dh_q;
  logic       idle, op_wr, key_op, dma_op, guard_ok;
  assign idle     = !STATUS[AKRC_ST_BSY] && !STATUS[AKRC_ST_DRQ];
  assign op_wr    = WR_STB && idle && ADDR == AKRC_OFF_OPCODE;
  assign key_op   = op_wr && WDATA == AKRC_OP_KEYMGMT;
  assign dma_op   = op_wr && WDATA == AKRC_OP_RDDMA;
  assign guard_ok = feat_q == AKRC_FEAT_KEYCHG && {hi_q, lo_q} == AKRC_GUARD_WORD;
  always_ff @(posedge CLK) begin
    if (WR_STB && idle && ADDR == AKRC_OFF_FEATURE) feat_q <= WDATA;
    if (WR_STB && idle && ADDR == AKRC_OFF_SECIDX) sec_q <= WDATA;
    if (WR_STB && idle && ADDR == AKRC_OFF_CYLLO) lo_q <= WDATA;
    if (WR_STB && idle && ADDR == AKRC_OFF_CYLHI) hi_q <= WDATA;
    if (WR_STB && idle && ADDR == AKRC_OFF_DRVHD) dh_q <= WDATA;
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  AST_NOP_ABORT: assert property (
    op_wr && WDATA == AKRC_OP_NOP |=> STATUS == 8'h41 && ERROR == AKRC_ERR_ABRT && INTRQ)
    else $error("nop not aborted");
  AST_KEY_GUARD: assert property (
    key_op && guard_ok |-> MEDIA_CHG ##1 STATUS == AKRC_RST_STATUS && INTRQ)
    else $error("guarded change not done");
  AST_KEY_REFUSE: assert property (
    key_op && !guard_ok && feat_q != AKRC_FEAT_KEYREAD |-> !MEDIA_CHG ##1 ERROR == AKRC_ERR_ABRT && STATUS[0])
    else $error("bad key subcommand not aborted");
  AST_KEY_READ: assert property (
    key_op && feat_q == AKRC_FEAT_KEYREAD |=> STATUS[AKRC_ST_BSY] &&
      MEDIA_REQ && MEDIA_SRC == 2'h1 && MEDIA_ADDR[15:0] == {lo_q, sec_q})
    else $error("keying read start wrong");
  AST_DMA_8BIT: assert property (
    dma_op && EIGHT_BIT_MODE |=> ERROR == AKRC_ERR_ABRT && !DMARQ && !MEDIA_REQ)
    else $error("dma in byte mode not aborted");
  AST_DMA_START: assert property (
    dma_op && !EIGHT_BIT_MODE && dh_q[AKRC_DH_LBA] |=> STATUS[AKRC_ST_BSY] &&
      MEDIA_REQ && MEDIA_SRC == 2'h0 && MEDIA_CHK && MEDIA_ADDR == {dh_q[3:0], hi_q, lo_q, sec_q})
    else $error("dma start wrong");
  AST_DMA_QUIET: assert property (DMARQ |-> !INTRQ)
    else $error("interrupt during dma");
  AST_RDBUF: assert property (
    op_wr && WDATA == AKRC_OP_RDBUF |=> STATUS[AKRC_ST_BSY] && MEDIA_REQ && MEDIA_SRC == 2'h2)
    else $error("buffer read start wrong");
  AST_LONG_NOCHK: assert property (
    op_wr && WDATA[7:1] == AKRC_OP_RDLONG0[7:1] |=> MEDIA_REQ && !MEDIA_CHK)
    else $error("long read verifies check bytes");
  AST_IRQ_IDLE: assert property ($rose(INTRQ) |-> !STATUS[AKRC_ST_BSY])
    else $error("interrupt while busy");
endmodule : akrc_exec_assertions

bind akrc_exec akrc_exec_assertions i_akrc_chk (
  .CLK(CLK), .NRST(NRST), .ADDR(ADDR), .WR_STB(WR_STB), .WDATA(WDATA), .STATUS(STATUS),
  .ERROR(ERROR), .INTRQ(INTRQ), .EIGHT_BIT_MODE(EIGHT_BIT_MODE), .DMARQ(DMARQ),
  .MEDIA_REQ(MEDIA_REQ), .MEDIA_SRC(MEDIA_SRC), .MEDIA_ADDR(MEDIA_ADDR),
  .MEDIA_CHK(MEDIA_CHK), .MEDIA_CHG(MEDIA_CHG)
);

// ===== verif/akrc_media_model.sv
// akrc_media_model: flash-side word source for the executor's media port
// assumes: the bench sets the word budget of each request before issuing it
module akrc_media_model
  import akrc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        req,
  input  wire logic        ready,
  input  wire logic [15:0] limit,
  input  wire logic        slow,
  input  wire logic        err_arm,
  output logic             valid,
  output logic [15:0]      data,
  output logic             err
);
  // ----------------------------------------
  // word stream
  // ----------------------------------------
  logic [15:0] idx_q, left_q;
  logic        tick_q;
  assign valid = left_q != 16'h0000 && !(slow && tick_q);
  assign data  = valid ? idx_q ^ 16'h5a00 : ~(idx_q ^ 16'h5a00);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {idx_q, left_q, tick_q, err} <= '0;
    end else begin
      tick_q <= ~tick_q;
      if (req) {idx_q, left_q, err} <= {16'h0000, limit, err_arm};
      else if (valid && ready) {idx_q, left_q} <= {idx_q + 16'h0001, left_q - 16'h0001};
    end
  end
endmodule : akrc_media_model

// ===== verif/ata_key_and_read_cmd_exec_test.sv
// ata_key_and_read_cmd_exec_test: directed command sequences for akrc_exec
// assumes: akrc_media_model feeds the word port; host strobes move on rising edges
module ata_key_and_read_cmd_exec_test import akrc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, nrst, wr_stb, rd_stb, eight_bit, dmack, dma_stb, chg_seen = 1'b0;
  logic        intrq, dmarq, m_req, m_chk, m_chg, m_valid, m_err, m_ready, m_slow, m_arm;
  logic [2:0]  addr;
  logic [7:0]  wdata, status, error;
  logic [15:0] rdata, m_data, m_limit, v;
  logic [1:0]  m_src, req_src;
  logic [27:0] m_addr, req_addr;
  logic [31:0] refuse [4] = '{32'h816eb200, 32'h820000b9, 32'h816eb3b9, 32'h000000c8};
  int          err_total, comparisons;
  akrc_exec i_dut (
    .CLK(clk), .NRST(nrst), .ADDR(addr), .WR_STB(wr_stb), .RD_STB(rd_stb), .WDATA(wdata),
    .RDATA(rdata), .STATUS(status), .ERROR(error), .INTRQ(intrq), .EIGHT_BIT_MODE(eight_bit),
    .DMARQ(dmarq), .DMACK(dmack), .DMA_RD_STB(dma_stb), .MEDIA_REQ(m_req), .MEDIA_SRC(m_src),
    .MEDIA_ADDR(m_addr), .MEDIA_CHK(m_chk), .MEDIA_CHG(m_chg), .MEDIA_VALID(m_valid),
    .MEDIA_DATA(m_data), .MEDIA_ERR(m_err), .MEDIA_READY(m_ready));
  akrc_media_model i_media (
    .clk(clk), .nrst(nrst), .req(m_req), .ready(m_ready), .limit(m_limit), .slow(m_slow),
    .err_arm(m_arm), .valid(m_valid), .data(m_data), .err(m_err));
  // ----------------------------------------
  // clock, request monitor, host tasks
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (m_req) req_addr <= m_addr;
    if (m_req) req_src <= m_src;
    if (m_chg) chg_seen <= 1'b1;
  end
  function automatic logic [15:0] pat(input int i);
    return 16'(i) ^ 16'h5a00;
  endfunction : pat
  task automatic chk(input string name, input logic [27:0] seen, input logic [27:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [15:0] val);
    @(posedge clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 val = rdata;
  endtask : rd
  task automatic cmd(input logic [7:0] f, c, s, lo, hi, dh, op);
    logic [7:0] r [1:7];
    r = '{f, c, s, lo, hi, dh, op};
    for (int i = 1; i < 8; i++) wr(3'(i), r[i]);
  endtask : cmd
  task automatic wait_st(input int b, input logic lvl);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (status[b] !== lvl && n < 3000);
    chk("status wait", 28'(status[b]), 28'(lvl));
  endtask : wait_st
  task automatic sector(input int nb);
    wait_st(AKRC_ST_DRQ, 1'b1);
    chk("irq at drq", 28'(intrq), 28'h1);
    rd(AKRC_OFF_OPCODE, v);
    for (int i = 0; i < 256 + nb; i++) begin
      rd(AKRC_OFF_DATA, v);
      if (i < 256) chk("pio word", 28'(v), 28'(pat(i)));
      else chk("check byte", 28'(v[7:0]), 28'(i - 256));
    end
  endtask : sector
  task automatic fin(input string name);
    repeat (20) @(posedge clk);
    #1 chk("end status", 28'(status), 28'(AKRC_RST_STATUS));
    $display("test %s done", name);
  endtask : fin
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    give_verdict();
  end
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  initial begin
    {nrst, wr_stb, rd_stb, eight_bit, dmack, dma_stb, m_slow, m_arm} = '0;
    {addr, wdata, m_limit, err_total, comparisons} = '0;
    repeat (20) @(posedge clk);
    chk("rst status", 28'(status), 28'(AKRC_RST_STATUS));
    chk("rst error", 28'(error), 28'h0);
    nrst <= 1'b1;
    foreach (refuse[i]) begin
      @(posedge clk);
      eight_bit <= refuse[i][7:0] == AKRC_OP_RDDMA;
      cmd(refuse[i][31:24], 8'h00, 8'h00, refuse[i][23:16], refuse[i][15:8], 8'h00, refuse[i][7:0]);
      repeat (2) @(posedge clk);
      #1 chk("abort status", 28'(status), 28'h41);
      chk("abort code", 28'(error), 28'(AKRC_ERR_ABRT));
      chk("abort irq", 28'(intrq), 28'h1);
      rd(AKRC_OFF_OPCODE, v);
      chk("irq cleared", 28'(intrq), 28'h0);
    end
    $display("test refusals done");
    @(posedge clk);
    eight_bit <= 1'b0;
    m_limit   <= 16'h0100;
    cmd(AKRC_FEAT_KEYCHG, 8'h00, 8'h00, AKRC_GUARD_WORD[7:0], AKRC_GUARD_WORD[15:8], 8'h00, AKRC_OP_KEYMGMT);
    repeat (2) @(posedge clk);
    #1 chk("chg pulse", 28'(chg_seen), 28'h1);
    chk("chg irq", 28'(intrq), 28'h1);
    fin("value change");
    cmd(AKRC_FEAT_KEYREAD, 8'h02, 8'h34, 8'h12, 8'h00, 8'h00, AKRC_OP_KEYMGMT);
    sector(0);
    chk("key src", 28'(req_src), 28'h1);
    chk("key offset", 28'(req_addr[15:0]), 28'h1234);
    sector(0);
    chk("key offset 2", 28'(req_addr[15:0]), 28'h1235);
    fin("keying read");
    cmd(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, AKRC_OP_RDBUF);
    sector(0);
    chk("buffer src", 28'(req_src), 28'h2);
    fin("buffer read");
    @(posedge clk);
    m_limit <= 16'h0104;
    for (int k = 0; k < 2; k++) begin
      cmd(8'h00, 8'h03, 8'h07, 8'h00, 8'h00, 8'he0, AKRC_OP_RDLONG0 | 8'(k));
      sector(4);
      fin("long read");
    end
    @(posedge clk);
    m_limit <= 16'h0200;
    cmd(8'h00, 8'h02, 8'h20, 8'h10, 8'h08, 8'he3, AKRC_OP_RDDMA);
    repeat (30) @(posedge clk);
    #1 chk("fifo full", 28'(m_ready), 28'h0);
    chk("dmarq on", 28'(dmarq), 28'h1);
    @(posedge clk);
    dmack  <= 1'b1;
    m_slow <= 1'b1;
    for (int i = 0; i < 512; i++) begin
      @(negedge clk);
      for (int n = 0; n < 300 && dmarq !== 1'b1; n++) @(negedge clk);
      if (i == 256) chk("irq mid dma", 28'(intrq), 28'h0);
      @(posedge clk);
      dma_stb <= 1'b1;
      @(posedge clk);
      dma_stb <= 1'b0;
      #1 chk("dma word", 28'(rdata), 28'(pat(i)));
    end
    @(posedge clk);
    dmack <= 1'b0;
    chk("dma lba", 28'(req_addr), 28'h3081020);
    wait_st(AKRC_ST_BSY, 1'b0);
    chk("dma irq", 28'(intrq), 28'h1);
    chk("fifo empty", 28'(dmarq), 28'h0);
    fin("dma read");
    wr(AKRC_OFF_OPCODE, AKRC_OP_RDBUF);
    sector(0);
    chk("last lba", 28'(req_addr), 28'h3081021);
    fin("dma address");
    @(posedge clk);
    m_limit <= 16'h0100;
    m_arm   <= 1'b1;
    cmd(AKRC_FEAT_KEYREAD, 8'h01, 8'h78, 8'h56, 8'h00, 8'h00, AKRC_OP_KEYMGMT);
    wait_st(AKRC_ST_BSY, 1'b0);
    chk("key error", 28'(error), 28'(AKRC_ERR_UNC));
    chk("error bit", 28'(status[AKRC_ST_ERR]), 28'h1);
    chk("error offset", 28'(req_addr[15:0]), 28'h5678);
    $display("test keying error done");
    give_verdict();
  end
endmodule : ata_key_and_read_cmd_exec_test
